//--- pkg/dlg_defs.svh
// Offsets, field positions, reset values for the demodulator loop configuration registers
`ifndef DLG_DEFS_SVH
`define DLG_DEFS_SVH

// ==========================================================================
// Register offsets
`define DLG_FREQ_OFFSET_COMP_CONFIG_ADDR 8'h19
`define DLG_BIT_SYNC_CONFIG_ADDR         8'h1a

// ==========================================================================
// freq_offset_comp_config fields
`define DLG_FOC_GATE_BIT      5
`define DLG_FREQ_GAIN_PRE_MSB  4
`define DLG_FREQ_GAIN_PRE_LSB  3
`define DLG_FREQ_GAIN_POST_BIT 2
`define DLG_FREQ_SAT_MSB       1
`define DLG_FREQ_SAT_LSB       0
`define DLG_FOC_USED_MSB      5
`define DLG_FOC_RESET         6'h36

// ==========================================================================
// bit_sync_config fields
`define DLG_CLKREC_KI_PRE_MSB  7
`define DLG_CLKREC_KI_PRE_LSB  6
`define DLG_CLKREC_KP_PRE_MSB  5
`define DLG_CLKREC_KP_PRE_LSB  4
`define DLG_CLKREC_KI_POST_BIT 3
`define DLG_BS_RESET          8'h6c

// ==========================================================================
// Gain encoding in half-units of the base gain, and base shift for the offset limit
`define DLG_GAIN_HALF         4'h1
`define DLG_LIMIT_SHIFT_BASE  3'h4

`endif

//--- pkg/dlg_pkg.sv
// Types shared by the demodulator loop configuration block
package dlg_pkg;

	// Two-bit gain select code
	typedef logic [1:0] dlg_code_t;

	// Gain in half-units of the base loop gain
	typedef logic [3:0] dlg_gain_t;

	// Frequency offset saturation codes
	typedef enum logic [1:0] {
		DLG_LIMIT_OFF     = 2'h0,
		DLG_LIMIT_EIGHTH  = 2'h1,
		DLG_LIMIT_QUARTER = 2'h2,
		DLG_LIMIT_HALF    = 2'h3
	} dlg_limit_e;

endpackage

//--- pkg/dlg_gain_if.sv
// Gain select request and decoded gain between controller and decoder
`timescale 1ns/1ps
`default_nettype none

interface dlg_gain_if;
	dlg_pkg::dlg_code_t code;
	logic               post_sel;
	logic               sync;
	dlg_pkg::dlg_gain_t gain;

	modport ctrl (output code, output post_sel, output sync, input gain);
	modport dec  (input code, input post_sel, input sync, output gain);
endinterface

`default_nettype wire

//--- src/dlg_gain_decode.sv
// Decodes a two-bit gain code and post-sync select into a gain in half-units
`timescale 1ns/1ps
`default_nettype none
`include "dlg_defs.svh"

module dlg_gain_decode (
	dlg_gain_if.dec g
);

	// ==========================================================================
	// Decode: code n gives (n+1) base gains, post-sync select gives half gain
	always_comb begin
		if (g.sync && g.post_sel) begin
			g.gain = `DLG_GAIN_HALF;
		end else begin
			g.gain = {3'(g.code) + 3'h1, 1'b0};
		end
	end

endmodule

`default_nettype wire

//--- src/dlg_loop_config.sv
// Register bank and gain selection for the demodulator offset and clock recovery loops
`timescale 1ns/1ps
`default_nettype none
`include "dlg_defs.svh"

module dlg_loop_config (
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic [7:0]         reg_addr_in,
	input  wire logic               reg_wr_en_in,
	input  wire logic [7:0]         reg_wr_data_in,
	input  wire logic               reg_rd_en_in,
	output logic      [7:0]         reg_rd_data_out,
	input  wire logic               sync_detected_in,
	input  wire logic               carrier_sense_in,
	output logic                    loop_freeze_out,
	output dlg_pkg::dlg_gain_t      freq_gain_out,
	output logic                    freq_comp_enable_out,
	output logic      [2:0]         freq_limit_shift_out,
	output dlg_pkg::dlg_gain_t      clkrec_integral_gain_out,
	output dlg_pkg::dlg_gain_t      clkrec_proportional_gain_out
);

	// ==========================================================================
	// Register state
	logic [5:0]         foc_q;
	logic [5:0]         foc_d;
	logic [7:0]         bs_q;
	logic [7:0]         bs_d;
	logic [7:0]         rd_q;
	logic [7:0]         rd_d;

	logic               loop_freeze_until_carrier;
	dlg_pkg::dlg_code_t freq_gain_pre_sync;
	logic               freq_gain_post_sync_sel;
	dlg_pkg::dlg_limit_e freq_offset_saturation;
	dlg_pkg::dlg_code_t clkrec_integral_pre_sync;
	dlg_pkg::dlg_code_t clkrec_proportional_pre_sync;
	logic               clkrec_integral_post_sync_sel;

	// Field views of the stored registers
	assign loop_freeze_until_carrier     = foc_q[`DLG_FOC_GATE_BIT];
	assign freq_gain_pre_sync            = foc_q[`DLG_FREQ_GAIN_PRE_MSB:`DLG_FREQ_GAIN_PRE_LSB];
	assign freq_gain_post_sync_sel       = foc_q[`DLG_FREQ_GAIN_POST_BIT];
	assign freq_offset_saturation        =
		dlg_pkg::dlg_limit_e'(foc_q[`DLG_FREQ_SAT_MSB:`DLG_FREQ_SAT_LSB]);
	assign clkrec_integral_pre_sync      = bs_q[`DLG_CLKREC_KI_PRE_MSB:`DLG_CLKREC_KI_PRE_LSB];
	assign clkrec_proportional_pre_sync  = bs_q[`DLG_CLKREC_KP_PRE_MSB:`DLG_CLKREC_KP_PRE_LSB];
	assign clkrec_integral_post_sync_sel = bs_q[`DLG_CLKREC_KI_POST_BIT];

	// Register writes and read data; unused top bits are never stored
	always_comb begin
		foc_d = foc_q;
		bs_d  = bs_q;
		rd_d  = rd_q;
		if (reg_wr_en_in && reg_addr_in == `DLG_FREQ_OFFSET_COMP_CONFIG_ADDR) begin
			foc_d = reg_wr_data_in[`DLG_FOC_USED_MSB:0];
		end
		if (reg_wr_en_in && reg_addr_in == `DLG_BIT_SYNC_CONFIG_ADDR) begin
			bs_d = reg_wr_data_in;
		end
		if (reg_rd_en_in) begin
			unique case (reg_addr_in)
				`DLG_FREQ_OFFSET_COMP_CONFIG_ADDR: rd_d = {2'h0, foc_q};
				`DLG_BIT_SYNC_CONFIG_ADDR:         rd_d = bs_q;
				default:                           rd_d = 8'h00;
			endcase
		end
	end

	// Register and read data flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			foc_q <= `DLG_FOC_RESET;
			bs_q  <= `DLG_BS_RESET;
			rd_q  <= 8'h00;
		end else begin
			foc_q <= foc_d;
			bs_q  <= bs_d;
			rd_q  <= rd_d;
		end
	end

	assign reg_rd_data_out = rd_q;

	// ==========================================================================
	// Gain decoders
	dlg_gain_if freq_g ();
	dlg_gain_if ki_g ();
	dlg_gain_if kp_g ();

	// Frequency loop gain, set to half a base gain after sync when selected
	assign freq_g.code     = freq_gain_pre_sync;
	assign freq_g.post_sel = freq_gain_post_sync_sel;
	assign freq_g.sync     = sync_detected_in;
	// Integral gain switches at sync
	assign ki_g.code       = clkrec_integral_pre_sync;
	assign ki_g.post_sel   = clkrec_integral_post_sync_sel;
	assign ki_g.sync       = sync_detected_in;
	// Proportional gain has no post-sync setting here
	assign kp_g.code       = clkrec_proportional_pre_sync;
	assign kp_g.post_sel   = 1'b0;
	assign kp_g.sync       = sync_detected_in;

	dlg_gain_decode u_freq_dec (.g(freq_g));
	dlg_gain_decode u_ki_dec   (.g(ki_g));
	dlg_gain_decode u_kp_dec   (.g(kp_g));

	// ==========================================================================
	// Registered loop controls
	logic               freeze_q;
	logic               freeze_d;
	dlg_pkg::dlg_gain_t fgain_q;
	dlg_pkg::dlg_gain_t fgain_d;
	dlg_pkg::dlg_gain_t kigain_q;
	dlg_pkg::dlg_gain_t kigain_d;
	dlg_pkg::dlg_gain_t kpgain_q;
	dlg_pkg::dlg_gain_t kpgain_d;
	logic               fen_q;
	logic               fen_d;
	logic [2:0]         shift_q;
	logic [2:0]         shift_d;

	// Freeze, gains and saturation for the datapath
	always_comb begin
		freeze_d = loop_freeze_until_carrier && !carrier_sense_in;
		fgain_d  = freq_g.gain;
		kigain_d = ki_g.gain;
		kpgain_d = kp_g.gain;
		fen_d    = freq_offset_saturation != dlg_pkg::DLG_LIMIT_OFF;
		shift_d  = `DLG_LIMIT_SHIFT_BASE - 3'(freq_offset_saturation);
	end

	// Loop control output flops, cleared while in reset
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			freeze_q <= 1'b0;
			fgain_q  <= 4'h0;
			kigain_q <= 4'h0;
			kpgain_q <= 4'h0;
			fen_q    <= 1'b0;
			shift_q  <= 3'h0;
		end else begin
			freeze_q <= freeze_d;
			fgain_q  <= fgain_d;
			kigain_q <= kigain_d;
			kpgain_q <= kpgain_d;
			fen_q    <= fen_d;
			shift_q  <= shift_d;
		end
	end

	assign loop_freeze_out              = freeze_q;
	assign freq_gain_out                = fgain_q;
	assign clkrec_integral_gain_out     = kigain_q;
	assign clkrec_proportional_gain_out = kpgain_q;
	assign freq_comp_enable_out         = fen_q;
	assign freq_limit_shift_out         = shift_q;

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_freeze_held;
		rst_n_in && loop_freeze_until_carrier && !carrier_sense_in |=> loop_freeze_out;
	endproperty
	a_freeze_held: assert property (p_freeze_held) else $error("Loop not frozen");

	property p_freeze_release;
		carrier_sense_in ##1 carrier_sense_in |-> loop_freeze_out == 1'b0;
	endproperty
	a_freeze_release: assert property (p_freeze_release) else $error("Loop stuck frozen");

	property p_freq_pre;
		rst_n_in && !sync_detected_in |=>
			freq_gain_out == {3'($past(freq_gain_pre_sync)) + 3'h1, 1'b0};
	endproperty
	a_freq_pre: assert property (p_freq_pre) else $error("Bad pre-sync freq gain");

	property p_freq_post;
		rst_n_in && sync_detected_in |=> freq_gain_out == ($past(freq_gain_post_sync_sel) ?
			4'h1 : {3'($past(freq_gain_pre_sync)) + 3'h1, 1'b0});
	endproperty
	a_freq_post: assert property (p_freq_post) else $error("Bad post-sync freq gain");

	property p_limit;
		rst_n_in |=> (freq_comp_enable_out == ($past(freq_offset_saturation) != 2'h0))
			&& (!freq_comp_enable_out || freq_limit_shift_out == 3'h4 - 3'($past(foc_q[1:0])));
	endproperty
	a_limit: assert property (p_limit) else $error("Bad offset saturation");

	property p_ki_pre;
		rst_n_in && !sync_detected_in |=> clkrec_integral_gain_out ==
			{3'($past(clkrec_integral_pre_sync)) + 3'h1, 1'b0};
	endproperty
	a_ki_pre: assert property (p_ki_pre) else $error("Bad pre-sync integral gain");

	property p_kp;
		rst_n_in |=> clkrec_proportional_gain_out ==
			{3'($past(clkrec_proportional_pre_sync)) + 3'h1, 1'b0};
	endproperty
	a_kp: assert property (p_kp) else $error("Bad proportional gain");

	property p_ki_post;
		rst_n_in && sync_detected_in && clkrec_integral_post_sync_sel |=>
			clkrec_integral_gain_out == 4'h1;
	endproperty
	a_ki_post: assert property (p_ki_post) else $error("Integral gain not halved");

	property p_unused_zero;
		reg_rd_en_in && reg_addr_in == 8'h19 |=> reg_rd_data_out[7:6] == 2'h0
			&& reg_rd_data_out[5:0] == $past(foc_q);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("Unused bits not zero");

endmodule

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench for the demodulator loop configuration registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic               clk_in;
	logic               rst_n_in;
	logic [7:0]         reg_addr_in;
	logic               reg_wr_en_in;
	logic [7:0]         reg_wr_data_in;
	logic               reg_rd_en_in;
	logic [7:0]         reg_rd_data_out;
	logic               sync_detected_in;
	logic               carrier_sense_in;
	logic               loop_freeze_out;
	dlg_pkg::dlg_gain_t freq_gain_out;
	logic               freq_comp_enable_out;
	logic [2:0]         freq_limit_shift_out;
	dlg_pkg::dlg_gain_t clkrec_integral_gain_out;
	dlg_pkg::dlg_gain_t clkrec_proportional_gain_out;
	int                 n_mismatch = 0;
	int                 n_tests = 0;
	int                 n_cycles = 0;
	logic [1:0]         c;
	logic [3:0]         g;

	dlg_loop_config dut (
		.clk_in                       (clk_in),
		.rst_n_in                     (rst_n_in),
		.reg_addr_in                  (reg_addr_in),
		.reg_wr_en_in                 (reg_wr_en_in),
		.reg_wr_data_in               (reg_wr_data_in),
		.reg_rd_en_in                 (reg_rd_en_in),
		.reg_rd_data_out              (reg_rd_data_out),
		.sync_detected_in             (sync_detected_in),
		.carrier_sense_in             (carrier_sense_in),
		.loop_freeze_out              (loop_freeze_out),
		.freq_gain_out                (freq_gain_out),
		.freq_comp_enable_out         (freq_comp_enable_out),
		.freq_limit_shift_out         (freq_limit_shift_out),
		.clkrec_integral_gain_out     (clkrec_integral_gain_out),
		.clkrec_proportional_gain_out (clkrec_proportional_gain_out)
	);

	// ======================================================================
	// Clock and hang guard
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// Cuts the run short if it hangs
	always @(posedge clk_in) begin
		n_cycles <= n_cycles + 1;
		if (n_cycles == 1000) begin
			n_mismatch++;
			final_report();
		end
	end

	// ======================================================================
	// Shared tasks
	// Counts a comparison, reports a mismatch
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		reg_addr_in <= addr;
		reg_wr_data_in <= data;
		reg_wr_en_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_en_in <= 1'b0;
	endtask

	// One-cycle read strobe, data compared once registered
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge clk_in);
		reg_addr_in <= addr;
		reg_rd_en_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_en_in <= 1'b0;
		@(posedge clk_in);
		#1;
		check(reg_rd_data_out, exp);
	endtask

	// Changes loop status inputs, lets outputs settle
	task automatic set_status(input logic sync, input logic cs);
		@(posedge clk_in);
		sync_detected_in <= sync;
		carrier_sense_in <= cs;
		repeat (3) @(posedge clk_in);
		#1;
	endtask

	// Compares all loop control outputs
	task automatic chk_outs(input logic f, input logic [3:0] fg, input logic en,
			input logic [2:0] sh, input logic [3:0] ki, input logic [3:0] kp);
		check({7'h0, loop_freeze_out}, {7'h0, f});
		check({4'h0, freq_gain_out}, {4'h0, fg});
		check({7'h0, freq_comp_enable_out}, {7'h0, en});
		check({5'h0, freq_limit_shift_out}, {5'h0, sh});
		check({4'h0, clkrec_integral_gain_out}, {4'h0, ki});
		check({4'h0, clkrec_proportional_gain_out}, {4'h0, kp});
	endtask

	// Prints the counts and the verdict, ends the run
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		rst_n_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wr_en_in = 1'b0;
		reg_wr_data_in = 8'h00;
		reg_rd_en_in = 1'b0;
		sync_detected_in = 1'b0;
		carrier_sense_in = 1'b0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// Reset contents and decoded outputs
		rd_chk(8'h19, 8'h36);
		rd_chk(8'h1a, 8'h6c);
		set_status(1'b0, 1'b0);
		chk_outs(1'b1, 4'h6, 1'b1, 3'h2, 4'h4, 4'h6);
		// Every gain and limit code, both post-sync selects, gate cases
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			g = {1'b0, c, 1'b0} + 4'h2;
			wr(8'h19, {2'b11, ^c, c, c[0], c});
			wr(8'h1a, {c, c, c[0], 3'h5});
			set_status(1'b0, c[1]);
			chk_outs(^c & ~c[1], g, c != 2'h0, (c == 2'h0) ? 3'h4 : 3'h4 - {1'b0, c},
				g, g);
			set_status(1'b1, c[1]);
			chk_outs(^c & ~c[1], c[0] ? 4'h1 : g, c != 2'h0,
				(c == 2'h0) ? 3'h4 : 3'h4 - {1'b0, c}, c[0] ? 4'h1 : g, g);
			rd_chk(8'h19, {2'b00, ^c, c, c[0], c});
			rd_chk(8'h1a, {c, c, c[0], 3'h5});
		end
		// Unmapped address leaves both registers alone
		wr(8'h1b, 8'hff);
		rd_chk(8'h1b, 8'h00);
		rd_chk(8'h19, 8'h1f);
		rd_chk(8'h1a, 8'hfd);
		final_report();
	end
endmodule

`default_nettype wire
